// ### hw/bci_pkg.sv
package bci_pkg;
   localparam logic [6:0] ADDR_POWER_RATE = 7'h20;
   localparam logic [6:0] ADDR_BOOT_FIFO = 7'h21;
   localparam logic [6:0] ADDR_IRQ_PIN = 7'h22;
   localparam logic [6:0] ADDR_IRQ_ROUTE = 7'h23;
   localparam logic [6:0] ADDR_DIFF_CFG = 7'h24;
   localparam logic [6:0] ADDR_IRQ_SOURCE = 7'h25;
   localparam logic [6:0] ADDR_REF_XL = 7'h08;
   localparam logic [6:0] ADDR_REF_L = 7'h09;
   localparam logic [6:0] ADDR_REF_H = 7'h0A;
   localparam logic [6:0] ADDR_STATUS = 7'h27;
   localparam logic [6:0] ADDR_POUT_XL = 7'h28;
   localparam logic [6:0] ADDR_POUT_L = 7'h29;
   localparam logic [6:0] ADDR_POUT_H = 7'h2A;
   localparam logic [6:0] ADDR_THS_L = 7'h30;
   localparam logic [6:0] ADDR_THS_H = 7'h31;
   localparam logic [6:0] ADDR_DEF_L = 7'h39;
   localparam logic [6:0] ADDR_DEF_H = 7'h3A;
   localparam logic [7:0] RESET_CTRL = 8'h00;
   localparam logic [7:0] RESET_DEF_L = 8'h38;
   localparam logic [7:0] RESET_DEF_H = 8'h00;
   localparam int BIT_POWER_ON = 7;
   localparam int BIT_RATE_LO = 4;
   localparam int BIT_DIFFERENTIAL_ENABLE = 3;
   localparam int BIT_BLOCK_UPDATE = 2;
   localparam int BIT_AZ_CLEAR = 1;
   localparam int BIT_WIRE_MODE = 0;
   localparam int BIT_REBOOT = 7;
   localparam int BIT_FIFO_EN = 6;
   localparam int BIT_LEVEL_MARK = 5;
   localparam int BIT_AVG_DEC = 4;
   localparam int BIT_I2C_OFF = 3;
   localparam int BIT_SOFT_RESET = 2;
   localparam int BIT_AZ_ENABLE = 1;
   localparam int BIT_ONE_SHOT = 0;
   localparam int BIT_IRQ_LOW = 7;
   localparam int BIT_IRQ_OD = 6;
   localparam int BIT_IRQ_LATCH = 2;
   localparam int BIT_LOW_EN = 1;
   localparam int BIT_HIGH_EN = 0;
   localparam logic [7:0] MASK_IRQ_PIN = 8'hC3;
   localparam logic [7:0] MASK_IRQ_ROUTE = 8'h0F;
   localparam logic [7:0] MASK_DIFF_CFG = 8'h07;
   // rate periods in link-clock ticks; 100 Hz tick assumed for the link clock
   localparam int RATE_TICK_HZ = 100;
   localparam int RATE_1HZ_TICKS = RATE_TICK_HZ / 1;
   localparam int RATE_7HZ_TICKS = RATE_TICK_HZ / 7;
   localparam int RATE_12HZ_TICKS = (RATE_TICK_HZ * 2) / 25;
   localparam int RATE_25HZ_TICKS = RATE_TICK_HZ / 25;
   localparam int CONV_TICKS = 4;
   typedef enum logic [2:0] {
      RATE_ONE_SHOT, RATE_1HZ, RATE_7HZ, RATE_12HZ5, RATE_25HZ
   } bci_rate_t;
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [6:0] addr;
      logic [7:0] wdata;
   } bci_req_t;
   typedef struct packed {
      logic empty;
      logic levelMark;
      logic overrun;
   } bci_fifo_flags_t;
   typedef struct packed {
      logic powerOn;
      logic diffEnable;
      logic rebootBusy;
      logic i2cDisable;
      logic wireModeSel;
      logic fifoEnable;
      logic levelMarkEnable;
      logic averageDecimate;
   } bci_cfg_t;
endpackage

// ### hw/bci_control_regs.sv
`timescale 1ns/1ps
// Contract
// R1: bit 7 of power_rate_control zero keeps measuring stopped; one runs it; here a one-shot still runs with bit 7 zero
// R2: rate field 000 one-shot, 001 1Hz, 010 7Hz, 011 12.5Hz, 100 25Hz
// R3: differential logic runs only while differential_enable is one
// R4: host should program reference and threshold before differential enable
// R5: block_update freezes output bytes between reading the first and last part
// R6: autozero_clear wipes reference, loads default pressure, then self-clears
// R7: wire_mode_sel zero selects 4-wire, one selects 3-wire serial
// R8: reboot reloads trimming after one rate cycle then self-clears
// R9: soft_reset with reboot restores power-on configuration, then self-clears
// R10: autozero enable captures pressure as reference; output becomes difference
// R11: in one-shot rate, one-shot bit starts one measurement, clears when done
// R12: control two bits 6,5,4 enable fifo, level mark, averaging decimation
// R13: interface bit zero keeps the i2c port enabled
// R14: irq_pin polarity: zero active high, one active low
// R15: irq_drive_type zero push-pull, one open-drain
// R16: irq_source_sel picks data signals, high, low, or low-or-high
// R17: data source routes empty, level mark, overrun, sample ready; 7:4 zero
// R18: routed sample ready marks a newly measured pressure sample
// R19: irq_latch holds requests in the source register; otherwise unlatched
// R20: low_event_enable below threshold, high_event_enable above threshold
// R21: interrupt source register clears when read
// R22: 24-bit reference is two's complement, combined with sensor pressure
// R23: thresholds compared once per sample on differential value; active flag
module bci_control_regs
   import bci_pkg::*;
#(
   parameter int PW = 24
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic meas_clk,
   input wire bci_req_t req,
   output logic [7:0] rdata,
   input wire logic [PW-1:0] sensorPressure,
   input wire bci_fifo_flags_t fifoFlags,
   output bci_cfg_t cfg,
   output logic irqPinOut,
   output logic irqPinOe
);
   logic [7:0] ctrl1Reg, ctrl2Reg, irqPinReg, routeReg, diffCfgReg;
   logic [7:0] srcReg, thsLReg, thsHReg, defLReg, defHReg;
   logic [PW-1:0] refReg, poutReg;
   logic pDaReg, pOrReg, lowSeenReg, highSeenReg;
   logic frozenReg;
   logic [2:0] doneSyncReg;
   logic [1:0] runSyncReg;
   logic [2:0] rateMetaReg;
   logic [2:0] rateLinkReg;
   logic runLinkReg, shotLinkReg;
   logic [1:0] shotSyncReg;
   logic [7:0] tickCntReg;
   logic doneToggleReg, shotAckReg;
   logic [1:0] ackSyncReg;
   logic rebootPendReg;
   logic [PW-1:0] diffVal;
   logic sampleDone, wr, rd, softReset;
   logic lowEvt, highEvt, irqRaw;

   function automatic logic [7:0] period_of(input logic [2:0] code);
      case (code)
         3'h1: period_of = 8'(RATE_1HZ_TICKS);
         3'h2: period_of = 8'(RATE_7HZ_TICKS);
         3'h3: period_of = 8'(RATE_12HZ_TICKS);
         3'h4: period_of = 8'(RATE_25HZ_TICKS);
         default: period_of = 8'h00; // reserved codes never run, see R2
      endcase
   endfunction

   assign wr = req.wrEn;
   assign rd = req.rdEn;

   // link-side settings cross as levels; rate is quasi-static
   always_ff @(posedge meas_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         runSyncReg <= 2'h0;
         rateMetaReg <= 3'h0;
         rateLinkReg <= 3'h0;
      end
      else
      begin
         runSyncReg <= {runSyncReg[0], ctrl1Reg[BIT_POWER_ON]}; // see R1
         // all three rate bits pass two flops, none is read raw
         rateMetaReg <= ctrl1Reg[BIT_RATE_LO +: 3]; // see R2
         rateLinkReg <= rateMetaReg;
      end
   end

   // one-shot request crosses as a toggle
   always_ff @(posedge meas_clk or negedge rstn)
   begin
      if (!rstn)
         shotSyncReg <= 2'h0;
      else
         shotSyncReg <= {shotSyncReg[0], shotLinkReg};
   end

   // measurement timebase in the link domain
   always_ff @(posedge meas_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tickCntReg <= 8'h00;
         doneToggleReg <= 1'b0;
         shotAckReg <= 1'b0;
      end
      else if (runSyncReg[1] && rateLinkReg != 3'h0 && period_of(rateLinkReg) != 8'h00)
      begin
         if (tickCntReg >= period_of(rateLinkReg) - 8'h01) // see R2
         begin
            tickCntReg <= 8'h00;
            doneToggleReg <= ~doneToggleReg;
         end
         else
            tickCntReg <= tickCntReg + 8'h01;
      end
      else if (shotSyncReg[1] != shotAckReg) // see R11
      begin
         if (tickCntReg >= 8'(CONV_TICKS - 1))
         begin
            tickCntReg <= 8'h00;
            doneToggleReg <= ~doneToggleReg;
            shotAckReg <= shotSyncReg[1];
         end
         else
            tickCntReg <= tickCntReg + 8'h01;
      end
      else
         tickCntReg <= 8'h00;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         doneSyncReg <= 3'h0;
         ackSyncReg <= 2'h0;
      end
      else
      begin
         doneSyncReg <= {doneSyncReg[1:0], doneToggleReg};
         ackSyncReg <= {ackSyncReg[0], shotAckReg};
      end
   end
   assign sampleDone = doneSyncReg[2] ^ doneSyncReg[1];

   // reference is two's complement; output is sensor minus reference
   assign diffVal = sensorPressure - refReg; // see R10, R22

   // soft reset is synchronous, one clock after the write that asks for it
   assign softReset = ctrl2Reg[BIT_SOFT_RESET] && ctrl2Reg[BIT_REBOOT]; // see R9

   // control registers, with self-clearing bits
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl1Reg <= RESET_CTRL;
         ctrl2Reg <= RESET_CTRL;
         irqPinReg <= RESET_CTRL;
         routeReg <= RESET_CTRL;
         diffCfgReg <= RESET_CTRL;
         thsLReg <= RESET_CTRL;
         thsHReg <= RESET_CTRL;
         defLReg <= RESET_DEF_L;
         defHReg <= RESET_DEF_H;
         shotLinkReg <= 1'b0;
         rebootPendReg <= 1'b0;
      end
      else if (softReset) // see R9
      begin
         ctrl1Reg <= RESET_CTRL;
         ctrl2Reg <= RESET_CTRL;
         irqPinReg <= RESET_CTRL;
         routeReg <= RESET_CTRL;
         diffCfgReg <= RESET_CTRL;
         thsLReg <= RESET_CTRL;
         thsHReg <= RESET_CTRL;
         defLReg <= RESET_DEF_L;
         defHReg <= RESET_DEF_H;
         shotLinkReg <= 1'b0;
         rebootPendReg <= 1'b0;
      end
      else
      begin
         if (wr && req.addr == ADDR_POWER_RATE)
            ctrl1Reg <= req.wdata & ~(8'h01 << BIT_AZ_CLEAR); // see R6
         if (wr && req.addr == ADDR_BOOT_FIFO)
         begin
            ctrl2Reg <= req.wdata; // see R12, R13
            if (req.wdata[BIT_ONE_SHOT] && ctrl1Reg[6:4] == 3'h0
                && ackSyncReg[1] == shotLinkReg)
               shotLinkReg <= ~shotLinkReg; // see R11
            rebootPendReg <= req.wdata[BIT_REBOOT];
         end
         else
         begin
            if (ctrl2Reg[BIT_ONE_SHOT] && ackSyncReg[1] == shotLinkReg && sampleDone)
               ctrl2Reg[BIT_ONE_SHOT] <= 1'b0; // see R11
            // reboot completes after one rate cycle
            if (rebootPendReg && sampleDone)
            begin
               ctrl2Reg[BIT_REBOOT] <= 1'b0; // see R8
               rebootPendReg <= 1'b0;
            end
         end
         if (wr && req.addr == ADDR_IRQ_PIN)
            irqPinReg <= req.wdata & MASK_IRQ_PIN;
         if (wr && req.addr == ADDR_IRQ_ROUTE)
            routeReg <= req.wdata & MASK_IRQ_ROUTE; // see R17
         if (wr && req.addr == ADDR_DIFF_CFG)
            diffCfgReg <= req.wdata & MASK_DIFF_CFG;
         if (wr && req.addr == ADDR_THS_L)
            thsLReg <= req.wdata;
         if (wr && req.addr == ADDR_THS_H)
            thsHReg <= req.wdata;
         if (wr && req.addr == ADDR_DEF_L)
            defLReg <= req.wdata;
         if (wr && req.addr == ADDR_DEF_H)
            defHReg <= req.wdata;
      end
   end

   // reference pressure bytes
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         refReg <= '0;
      else if (softReset)
         refReg <= '0; // see R9
      else if (wr && req.addr == ADDR_POWER_RATE && req.wdata[BIT_AZ_CLEAR])
         refReg <= PW'({defHReg, defLReg}); // see R6
      else if (wr && req.addr == ADDR_BOOT_FIFO && req.wdata[BIT_AZ_ENABLE]
               && !ctrl2Reg[BIT_AZ_ENABLE])
         refReg <= poutReg; // see R10
      else if (wr && req.addr == ADDR_REF_XL)
         refReg[7:0] <= req.wdata;
      else if (wr && req.addr == ADDR_REF_L)
         refReg[15:8] <= req.wdata;
      else if (wr && req.addr == ADDR_REF_H)
         refReg[23:16] <= req.wdata; // see R22
   end

   // output pressure and block update
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         poutReg <= '0;
         frozenReg <= 1'b0;
      end
      else
      begin
         if (rd && (req.addr == ADDR_POUT_XL || req.addr == ADDR_POUT_H))
            frozenReg <= ctrl1Reg[BIT_BLOCK_UPDATE] && !frozenReg; // see R5
         if (sampleDone && !(ctrl1Reg[BIT_BLOCK_UPDATE] && frozenReg))
            poutReg <= ctrl2Reg[BIT_AZ_ENABLE] ? diffVal : sensorPressure; // see R10
      end
   end

   // sample-ready and overrun
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pDaReg <= 1'b0;
         pOrReg <= 1'b0;
      end
      else if (sampleDone) // set wins over a clearing read
      begin
         pDaReg <= 1'b1; // see R18
         pOrReg <= pDaReg;
      end
      else if (rd && req.addr == ADDR_POUT_H)
      begin
         pDaReg <= 1'b0;
         pOrReg <= 1'b0;
      end
   end

   // threshold events evaluated per sample on the differential value
   assign highEvt = diffCfgReg[BIT_HIGH_EN] &&
                    $signed(diffVal) > $signed(PW'({thsHReg, thsLReg})); // see R20
   assign lowEvt = diffCfgReg[BIT_LOW_EN] &&
                   $signed(diffVal) < -$signed(PW'({thsHReg, thsLReg})); // see R20

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lowSeenReg <= 1'b0;
         highSeenReg <= 1'b0;
      end
      else if (sampleDone && ctrl1Reg[BIT_DIFFERENTIAL_ENABLE]) // see R3, R23
      begin
         lowSeenReg <= lowEvt || (diffCfgReg[BIT_IRQ_LATCH] && lowSeenReg && !rdSrc());
         highSeenReg <= highEvt || (diffCfgReg[BIT_IRQ_LATCH] && highSeenReg && !rdSrc());
      end
      else if (!ctrl1Reg[BIT_DIFFERENTIAL_ENABLE] || rdSrc()) // see R19, R21
      begin
         lowSeenReg <= 1'b0;
         highSeenReg <= 1'b0;
      end
   end

   function automatic logic rdSrc();
      rdSrc = rd && req.addr == ADDR_IRQ_SOURCE;
   endfunction

   always_comb
   begin
      srcReg = {5'h00, lowSeenReg || highSeenReg, lowSeenReg, highSeenReg}; // see R23
      case (irqPinReg[1:0]) // see R16
         2'h0: irqRaw = |({fifoFlags, pDaReg} & routeReg[3:0]); // see R17
         2'h1: irqRaw = highSeenReg;
         2'h2: irqRaw = lowSeenReg;
         default: irqRaw = lowSeenReg || highSeenReg;
      endcase
   end

   // open-drain drives only the asserted level
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irqPinOut <= 1'b0;
         irqPinOe <= 1'b1;
      end
      else
      begin
         irqPinOut <= irqRaw ^ irqPinReg[BIT_IRQ_LOW]; // see R14
         irqPinOe <= !irqPinReg[BIT_IRQ_OD] || irqRaw; // see R15
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         rdata <= 8'h00;
      else if (rd)
         case (req.addr)
            ADDR_POWER_RATE: rdata <= ctrl1Reg;
            ADDR_BOOT_FIFO: rdata <= ctrl2Reg;
            ADDR_IRQ_PIN: rdata <= irqPinReg;
            ADDR_IRQ_ROUTE: rdata <= routeReg;
            ADDR_DIFF_CFG: rdata <= diffCfgReg;
            ADDR_IRQ_SOURCE: rdata <= srcReg;
            ADDR_STATUS: rdata <= {2'h0, pOrReg, 3'h0, pDaReg, 1'b0};
            ADDR_REF_XL: rdata <= refReg[7:0];
            ADDR_REF_L: rdata <= refReg[15:8];
            ADDR_REF_H: rdata <= refReg[23:16];
            ADDR_POUT_XL: rdata <= poutReg[7:0];
            ADDR_POUT_L: rdata <= poutReg[15:8];
            ADDR_POUT_H: rdata <= poutReg[23:16];
            ADDR_THS_L: rdata <= thsLReg;
            ADDR_THS_H: rdata <= thsHReg;
            ADDR_DEF_L: rdata <= defLReg;
            ADDR_DEF_H: rdata <= defHReg;
            default: rdata <= 8'h00;
         endcase
   end

   assign cfg.powerOn = ctrl1Reg[BIT_POWER_ON]; // see R1
   assign cfg.diffEnable = ctrl1Reg[BIT_DIFFERENTIAL_ENABLE]; // see R3
   assign cfg.rebootBusy = ctrl2Reg[BIT_REBOOT]; // see R8
   assign cfg.i2cDisable = ctrl2Reg[BIT_I2C_OFF]; // see R13
   assign cfg.wireModeSel = ctrl1Reg[BIT_WIRE_MODE]; // see R7
   assign cfg.fifoEnable = ctrl2Reg[BIT_FIFO_EN]; // see R12
   assign cfg.levelMarkEnable = ctrl2Reg[BIT_LEVEL_MARK];
   assign cfg.averageDecimate = ctrl2Reg[BIT_AVG_DEC];
endmodule

// ### dv/bci_control_regs_chk.sv
`timescale 1ns/1ps
module bci_control_regs_chk
   import bci_pkg::*;
#(
   parameter int PW = 24
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic meas_clk,
   input wire bci_req_t req,
   input wire logic [7:0] rdata,
   input wire logic [PW-1:0] sensorPressure,
   input wire bci_fifo_flags_t fifoFlags,
   input wire bci_cfg_t cfg,
   input wire logic irqPinOut,
   input wire logic irqPinOe
);
   logic [7:0] pinShadow;
   logic [3:0] routeShadow;
   logic wrCtl;
   logic softHit;
   logic softHitReg;
   assign wrCtl = req.wrEn && req.addr == ADDR_BOOT_FIFO;
   assign softHit = wrCtl && req.wdata[BIT_REBOOT] && req.wdata[BIT_SOFT_RESET];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // the design applies the soft reset one clock after the write
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         softHitReg <= 1'b0;
      else
         softHitReg <= softHit;
   end
   // pad registers mirrored here, since only the ports are visible
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         pinShadow <= 8'h00;
      else if (softHitReg)
         pinShadow <= 8'h00;
      else if (req.wrEn && req.addr == ADDR_IRQ_PIN)
         pinShadow <= req.wdata & MASK_IRQ_PIN;
   end
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         routeShadow <= 4'h0;
      else if (softHitReg)
         routeShadow <= 4'h0;
      else if (req.wrEn && req.addr == ADDR_IRQ_ROUTE)
         routeShadow <= req.wdata[3:0];
   end
   a_power_bit: assert property (
      req.wrEn && req.addr == ADDR_POWER_RATE |=> cfg.powerOn == $past(req.wdata[BIT_POWER_ON]))
      else $error("power bit does not follow its write");
   a_diff_bit: assert property (
      req.wrEn && req.addr == ADDR_POWER_RATE |=> cfg.diffEnable == $past(req.wdata[BIT_DIFFERENTIAL_ENABLE]))
      else $error("differential enable does not follow its write");
   a_wire_mode: assert property (
      req.wrEn && req.addr == ADDR_POWER_RATE |=> cfg.wireModeSel == $past(req.wdata[0]))
      else $error("wire mode does not follow its write");
   a_fifo_bits: assert property (
      wrCtl && !softHit |=> {cfg.fifoEnable, cfg.levelMarkEnable, cfg.averageDecimate}
         == $past(req.wdata[6:4]))
      else $error("fifo controls do not follow their write");
   a_i2c_select: assert property (
      wrCtl && !softHit |=> cfg.i2cDisable == $past(req.wdata[BIT_I2C_OFF]))
      else $error("interface select does not follow its write");
   a_reboot_flag: assert property (
      wrCtl && !softHit && req.wdata[BIT_REBOOT] |=> cfg.rebootBusy)
      else $error("reboot not started by its write");
   a_unmapped_zero: assert property (
      req.rdEn && req.addr inside {7'h26, 7'h2D, 7'h7F} |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (
      !$past(req.rdEn) |-> $stable(rdata))
      else $error("read data moved without a read");
   a_pad_drive: assert property (
      $past(pinShadow[BIT_IRQ_OD]) == 1'b0 |-> irqPinOe)
      else $error("push-pull pad not driven");
   a_idle_level: assert property (
      $past(routeShadow) == 4'h0 && $past(pinShadow[6:0]) == 7'h00
         |-> irqPinOut == $past(pinShadow[BIT_IRQ_LOW]))
      else $error("inactive pad level wrong");
endmodule
bind bci_control_regs bci_control_regs_chk #(.PW(PW)) chk (
   .core_clk(core_clk), .rstn(rstn), .meas_clk(meas_clk), .req(req), .rdata(rdata),
   .sensorPressure(sensorPressure), .fifoFlags(fifoFlags), .cfg(cfg),
   .irqPinOut(irqPinOut), .irqPinOe(irqPinOe)
);

// ### dv/bci_host_model.sv
`timescale 1ns/1ps
module bci_host_model
   import bci_pkg::*;
(
   input wire logic core_clk,
   input wire logic [7:0] rdata,
   output bci_req_t req
);
   initial req = '0;
   // idle address and data are inverted so a stale value cannot pass as valid
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge core_clk);
      req = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
      @(negedge core_clk);
      req = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge core_clk);
      req = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
      @(negedge core_clk);
      req = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: 8'hFF};
      d = rdata;
   endtask
endmodule

// ### dv/test_baro_control_interrupt_regs.sv
`timescale 1ns/1ps
module test_baro_control_interrupt_regs
   import bci_pkg::*;
   ;
   logic core_clk;
   logic meas_clk;
   logic rstn;
   bci_req_t req;
   logic [7:0] rdata;
   logic [23:0] sensorPressure;
   bci_fifo_flags_t fifoFlags;
   bci_cfg_t cfg;
   logic irqPinOut;
   logic irqPinOe;
   int failures = 0;
   int checks = 0;

   bci_control_regs #(.PW(24)) dut (
      .core_clk(core_clk), .rstn(rstn), .meas_clk(meas_clk), .req(req), .rdata(rdata),
      .sensorPressure(sensorPressure), .fifoFlags(fifoFlags), .cfg(cfg),
      .irqPinOut(irqPinOut), .irqPinOe(irqPinOe)
   );
   bci_host_model host (.core_clk(core_clk), .rdata(rdata), .req(req));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial
   begin
      meas_clk = 1'b0;
      #3;
      forever #32 meas_clk = ~meas_clk;
   end

   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkb(input string n, input logic e, input logic g);
      chk8(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic rdchk(input logic [6:0] a, input logic [7:0] e, input string n);
      logic [7:0] d;
      host.rd(a, d);
      chk8(n, e, d);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic t_regs;
      logic [7:0] wv [5] = '{8'h9D, 8'h78, 8'hFF, 8'hFF, 8'hFF};
      logic [7:0] ev [5] = '{8'h9D, 8'h78, 8'hC3, 8'h0F, 8'h07};
      for (int i = 0; i < 6; i++)
         rdchk(ADDR_POWER_RATE + 7'(i), RESET_CTRL, "reset value");
      rdchk(ADDR_DEF_L, RESET_DEF_L, "default low");
      rdchk(ADDR_DEF_H, RESET_DEF_H, "default high");
      for (int i = 0; i < 5; i++)
      begin
         host.wr(ADDR_POWER_RATE + 7'(i), wv[i]);
         rdchk(ADDR_POWER_RATE + 7'(i), ev[i], "masked readback");
      end
      chk8("config", 8'hDF, cfg);
      host.wr(7'h26, 8'h5A);
      rdchk(7'h26, 8'h00, "unmapped");
      host.wr(ADDR_BOOT_FIFO, 8'h84);
      idle(4);
      rdchk(ADDR_POWER_RATE, 8'h00, "after soft reset");
      rdchk(ADDR_BOOT_FIFO, 8'h00, "soft reset bit");
      chk8("config reset", 8'h00, cfg);
      host.wr(ADDR_POWER_RATE, 8'h02);
      idle(8);
      rdchk(ADDR_POWER_RATE, 8'h00, "autozero clear bit");
      $display("t_regs done");
   endtask

   task automatic t_route;
      for (int i = 1; i < 4; i++)
      begin
         host.wr(ADDR_IRQ_PIN, 8'h00);
         host.wr(ADDR_IRQ_ROUTE, 8'(1 << i));
         fifoFlags = 3'(1 << (i - 1));
         idle(4);
         chkb("routed flag", 1'b1, irqPinOut);
         host.wr(ADDR_IRQ_PIN, 8'hC0);
         idle(4);
         chk8("open drain active", 8'h01, {6'h00, irqPinOut, irqPinOe});
         fifoFlags = '0;
         idle(4);
         chkb("open drain released", 1'b0, irqPinOe);
      end
      $display("t_route done");
   endtask

   task automatic t_events;
      logic [7:0] d;
      // threshold set before the differential logic runs
      host.wr(ADDR_THS_L, 8'h01);
      host.wr(ADDR_THS_H, 8'h00);
      host.wr(ADDR_DIFF_CFG, 8'h07);
      host.wr(ADDR_IRQ_ROUTE, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         sensorPressure = (k == 1) ? 24'h900000 : 24'h700000;
         host.wr(ADDR_IRQ_PIN, (k == 1) ? 8'h02 : 8'h01);
         host.wr(ADDR_POWER_RATE, 8'hC8);
         idle(RATE_25HZ_TICKS * 8 * 6);
         chkb("event pin", 1'b1, irqPinOut);
         host.wr(ADDR_POWER_RATE, 8'h08);
         idle(RATE_25HZ_TICKS * 8 * 6);
         host.rd(ADDR_IRQ_SOURCE, d);
         chk8("event source", (k == 1) ? 8'h06 : 8'h05, d);
         rdchk(ADDR_IRQ_SOURCE, 8'h00, "source cleared");
         idle(RATE_25HZ_TICKS * 8 * 6);
         rdchk(ADDR_IRQ_SOURCE, 8'h00, "no sampling when off");
      end
      $display("t_events done");
   endtask

   task automatic t_boot;
      host.wr(ADDR_POWER_RATE, 8'hC0);
      host.wr(ADDR_BOOT_FIFO, 8'h80);
      chkb("reboot busy", 1'b1, cfg.rebootBusy);
      idle(RATE_25HZ_TICKS * 8 * 6);
      rdchk(ADDR_BOOT_FIFO, 8'h00, "reboot cleared");
      $display("t_boot done");
   endtask

   task automatic t_shot;
      logic [7:0] d;
      sensorPressure = 24'h900000;
      host.wr(ADDR_POWER_RATE, 8'h80);
      host.wr(ADDR_IRQ_PIN, 8'h00);
      host.wr(ADDR_IRQ_ROUTE, 8'h01);
      idle(40);
      host.rd(ADDR_POUT_H, d);
      idle(8);
      chkb("ready before shot", 1'b0, irqPinOut);
      host.wr(ADDR_BOOT_FIFO, 8'h01);
      idle((CONV_TICKS + 4) * 8);
      chkb("ready after shot", 1'b1, irqPinOut);
      rdchk(ADDR_BOOT_FIFO, 8'h00, "shot bit cleared");
      // autozero takes the last output as reference, later outputs are differences
      host.wr(ADDR_BOOT_FIFO, 8'h02);
      rdchk(ADDR_REF_H, 8'h90, "autozero capture");
      sensorPressure = 24'h900010;
      host.wr(ADDR_BOOT_FIFO, 8'h03);
      idle((CONV_TICKS + 4) * 8);
      rdchk(ADDR_POUT_XL, 8'h10, "difference low");
      rdchk(ADDR_POUT_H, 8'h00, "difference high");
      // with block update, a sample landing between the two reads is held off
      host.wr(ADDR_POWER_RATE, 8'h84);
      rdchk(ADDR_POUT_XL, 8'h10, "frozen low");
      sensorPressure = 24'h910010;
      host.wr(ADDR_BOOT_FIFO, 8'h03);
      idle((CONV_TICKS + 4) * 8);
      rdchk(ADDR_POUT_H, 8'h00, "frozen high");
      $display("t_shot done");
   endtask

   task automatic give_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      rstn = 1'b0;
      sensorPressure = '0;
      fifoFlags = '0;
      repeat (16) @(negedge core_clk);
      rstn = 1'b1;
      t_regs;
      t_route;
      t_events;
      t_boot;
      t_shot;
      give_verdict;
   end
   initial
   begin
      repeat (20000) @(posedge core_clk);
      failures++;
      $display("watchdog expired");
      give_verdict;
   end
endmodule
